// File: hw/keypad_pkg.sv
package keypad_pkg;

  // ----------------------------------------------------------------
  // port geometry
  // ----------------------------------------------------------------
  localparam int PORT_W  = 8;
  localparam int LINES_W = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  // least settling time after a drive change, rounded up to cycles
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  // ----------------------------------------------------------------
  // reset values and fixed scan constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PULLUP_ALL   = 8'hff;
  localparam logic [7:0] PIN_OUT_RST  = 8'hff;
  localparam logic [7:0] PIN_OE_RST   = 8'h00;
  localparam logic [1:0] PHASE_FIRST  = 2'h0;
  localparam logic [1:0] PHASE_LAST   = 2'h3;
  localparam logic [3:0] SENSE_IDLE   = 4'hf;
  localparam logic [3:0] DRIVE_OE     = 4'hf;
  localparam logic [3:0] SENSE_OE     = 4'h0;

  // ----------------------------------------------------------------
  // scan states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_DECIDE = 2'b11
  } scan_state_t;

endpackage : keypad_pkg

// File: hw/scan_if.sv
`timescale 1ns/100ps
interface scan_if;
  logic       sample;
  logic [3:0] sense;
  logic       hit;
  logic [1:0] col;

  modport scanner (output sample, output sense, input hit, input col);
  modport sampler (input sample, input sense, output hit, output col);
endinterface : scan_if

// File: hw/key_sampler.sv
`timescale 1ns/100ps
module key_sampler
  import keypad_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // sense nibble in, decoded column out
  scan_if.sampler   sif
);

  logic       hit_ff;
  logic [1:0] col_ff;
  logic       nxt_hit;
  logic [1:0] nxt_col;

  // ----------------------------------------------------------------
  // decode: highest sense line wins, all high means nothing pressed
  // ----------------------------------------------------------------
  always_comb begin
    nxt_hit = hit_ff;
    nxt_col = col_ff;
    if (sif.sample) begin
      nxt_hit = (sif.sense != SENSE_IDLE);
      if (!sif.sense[3]) begin
        nxt_col = 2'h3;
      end else if (!sif.sense[2]) begin
        nxt_col = 2'h2;
      end else if (!sif.sense[1]) begin
        nxt_col = 2'h1;
      end else begin
        nxt_col = 2'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hit_ff <= 1'b0;
      col_ff <= 2'h0;
    end else begin
      hit_ff <= nxt_hit;
      col_ff <= nxt_col;
    end
  end

  assign sif.hit = hit_ff;
  assign sif.col = col_ff;

  property p_no_key_when_idle;
    @(posedge clock) disable iff (!rstn)
    sif.sample && (sif.sense == SENSE_IDLE) |=> !hit_ff;
  endproperty
  a_no_key_when_idle: assert property (p_no_key_when_idle)
    else $error("hit reported with all sense lines high");

endmodule : key_sampler

// File: hw/matrix_keypad_scanner.sv
`timescale 1ns/100ps
module matrix_keypad_scanner
  import keypad_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYCLES
)(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // mode select and general-purpose side
  input  wire logic              keypad_en,
  input  wire logic [PORT_W-1:0] gpio_out,
  input  wire logic [PORT_W-1:0] gpio_oe,
  output logic      [PORT_W-1:0] gpio_in,
  // port pins
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] pin_pullup,
  // key report
  output logic      [3:0]        key_code,
  output logic                   key_valid,
  output logic                   key_event
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] meta_ff;
  logic [PORT_W-1:0] sync_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= PIN_OUT_RST;
      sync_ff <= PIN_OUT_RST;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // scan sequencer
  // ----------------------------------------------------------------
  scan_if sif ();

  key_sampler key_sampler_i (
    .clock (clock),
    .rstn  (rstn),
    .sif   (sif)
  );

  scan_state_t      state_ff,  nxt_state;
  logic [CNT_W-1:0] cnt_ff,    nxt_cnt;
  logic [1:0]       phase_ff,  nxt_phase;
  logic             found_ff,  nxt_found;
  logic [3:0]       acc_ff,    nxt_acc;
  logic [3:0]       code_ff,   nxt_code;
  logic             valid_ff,  nxt_valid;
  logic             event_ff,  nxt_event;
  logic [1:0]       low_line;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // phase 0 pulls drive_line_3, phase 3 pulls drive_line_0
  assign low_line   = PHASE_LAST - phase_ff;
  assign sif.sample = (state_ff == ST_SAMPLE);
  assign sif.sense  = sync_ff[7:4];

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_phase = phase_ff;
    nxt_found = found_ff;
    nxt_acc   = acc_ff;
    nxt_code  = code_ff;
    nxt_valid = valid_ff;
    nxt_event = 1'b0;
    if (!keypad_en) begin
      nxt_state = ST_IDLE;
      nxt_valid = 1'b0;
      nxt_found = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_SETTLE;
          nxt_cnt   = '0;
          nxt_phase = PHASE_FIRST;
          nxt_found = 1'b0;
        end
        ST_SETTLE: begin
          // the drive lines just changed; wait for the matrix to settle
          if (cnt_ff == SETTLE_LAST) begin
            nxt_state = ST_SAMPLE;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
        ST_SAMPLE: begin
          nxt_state = ST_DECIDE;
        end
        ST_DECIDE: begin
          // first hit in scan order wins, so key 15 outranks key 0
          if (sif.hit && !found_ff) begin
            nxt_found = 1'b1;
            nxt_acc   = {low_line, sif.col};
          end
          nxt_state = ST_SETTLE;
          nxt_cnt   = '0;
          nxt_phase = phase_ff + 1'b1;
          if (phase_ff == PHASE_LAST) begin
            nxt_found = 1'b0;
            nxt_valid = found_ff || sif.hit;
            nxt_code  = found_ff ? acc_ff : {low_line, sif.col};
            nxt_event = nxt_valid && (!valid_ff || nxt_code != code_ff);
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      phase_ff <= PHASE_FIRST;
      found_ff <= 1'b0;
      acc_ff   <= 4'h0;
      code_ff  <= 4'h0;
      valid_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      phase_ff <= nxt_phase;
      found_ff <= nxt_found;
      acc_ff   <= nxt_acc;
      code_ff  <= nxt_code;
      valid_ff <= nxt_valid;
      event_ff <= nxt_event;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] out_ff, nxt_out;
  logic [PORT_W-1:0] oe_ff,  nxt_oe;
  logic [PORT_W-1:0] pu_ff;
  logic [1:0]        nxt_low;

  // drive lines are pushed high actively, never left to the pull-ups,
  // so the unselected rows cannot float into a false hit
  always_comb begin
    nxt_low = PHASE_LAST - nxt_phase;
    if (keypad_en) begin
      nxt_out = {SENSE_IDLE, ~(4'h1 << nxt_low)};
      nxt_oe  = {SENSE_OE, DRIVE_OE};
    end else begin
      nxt_out = gpio_out;
      nxt_oe  = gpio_oe;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_ff <= PIN_OUT_RST;
      oe_ff  <= PIN_OE_RST;
      pu_ff  <= PULLUP_ALL;
    end else begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
      pu_ff  <= PULLUP_ALL;
    end
  end

  assign pin_out    = out_ff;
  assign pin_oe     = oe_ff;
  assign pin_pullup = pu_ff;
  assign gpio_in    = sync_ff;
  assign key_code   = code_ff;
  assign key_valid  = valid_ff;
  assign key_event  = event_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_phase0_drive;
    @(posedge clock) disable iff (!rstn)
    keypad_en && state_ff == ST_SAMPLE && phase_ff == 2'h0
      |-> out_ff[3:0] == 4'h7 && oe_ff == 8'h0f;
  endproperty
  a_phase0_drive: assert property (p_phase0_drive)
    else $error("phase 0 does not pull drive_line_3 alone");

  property p_phase1_drive;
    @(posedge clock) disable iff (!rstn)
    keypad_en && state_ff == ST_SAMPLE && phase_ff == 2'h1
      |-> out_ff[3:0] == 4'hb;
  endproperty
  a_phase1_drive: assert property (p_phase1_drive)
    else $error("phase 1 does not pull drive_line_2 alone");

  property p_phase2_drive;
    @(posedge clock) disable iff (!rstn)
    keypad_en && state_ff == ST_SAMPLE && phase_ff == 2'h2
      |-> out_ff[3:0] == 4'hd;
  endproperty
  a_phase2_drive: assert property (p_phase2_drive)
    else $error("phase 2 does not pull drive_line_1 alone");

  property p_phase3_key;
    @(posedge clock) disable iff (!rstn)
    keypad_en && state_ff == ST_SAMPLE && phase_ff == 2'h3 && !found_ff
      && sync_ff[7:4] == 4'he ##1 keypad_en
      |=> valid_ff && code_ff == 4'h0;
  endproperty
  a_phase3_key: assert property (p_phase3_key)
    else $error("sense_line_4 low in last phase is not key 0");

  property p_pullups;
    @(posedge clock) disable iff (!rstn)
    pu_ff == PULLUP_ALL;
  endproperty
  a_pullups: assert property (p_pullups)
    else $error("pull-up missing on a port line");

  property p_gpio_release;
    @(posedge clock) disable iff (!rstn)
    !keypad_en |=> oe_ff == $past(gpio_oe) && out_ff == $past(gpio_out)
      && !valid_ff;
  endproperty
  a_gpio_release: assert property (p_gpio_release)
    else $error("port not released to general-purpose use");

  property p_settle_hold;
    @(posedge clock) disable iff (!rstn)
    keypad_en && state_ff == ST_SETTLE && cnt_ff != SETTLE_LAST
      |=> !keypad_en || state_ff == ST_SETTLE;
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("sample taken before settling ended");

  property p_phase_advance;
    @(posedge clock) disable iff (!rstn)
    keypad_en && state_ff == ST_DECIDE ##1 keypad_en
      |-> state_ff == ST_SETTLE && phase_ff == $past(phase_ff) + 2'h1;
  endproperty
  a_phase_advance: assert property (p_phase_advance)
    else $error("scan did not move to the next phase");

  c_key_reported: cover property (@(posedge clock) disable iff (!rstn)
    $rose(valid_ff));
  c_key15: cover property (@(posedge clock) disable iff (!rstn)
    valid_ff && code_ff == 4'hf);
  c_gpio_mode: cover property (@(posedge clock) disable iff (!rstn)
    !keypad_en ##1 keypad_en);

endmodule : matrix_keypad_scanner

// File: verif/keypad_model.sv
`timescale 1ns/100ps
module keypad_model (
  // design side of the port
  input  wire logic [7:0]  pin_out,
  input  wire logic [7:0]  pin_oe,
  input  wire logic [7:0]  pin_pullup,
  // keys held and outside drivers
  input  wire logic [15:0] key_down,
  input  wire logic [7:0]  ext_oe,
  input  wire logic [7:0]  ext_val,
  // resolved pin levels
  output logic      [7:0]  pin_in
);
  logic [7:0] lvl;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) lvl[i] = pin_out[i];
      else if (ext_oe[i]) lvl[i] = ext_val[i];
      else if (pin_pullup[i]) lvl[i] = 1'b1;
      else lvl[i] = ~pin_out[i];
    end
    pin_in = lvl;
    // a closed switch ties one drive line to one sense line; both
    // wirings only rename rows and columns, so one model serves both
    for (int d = 0; d < 4; d++) begin
      for (int s = 0; s < 4; s++) begin
        if (key_down[d*4+s] && !lvl[d]) pin_in[s+4] = 1'b0;
      end
    end
  end
endmodule : keypad_model

// File: verif/matrix_keypad_scanner_tb.sv
`timescale 1ns/100ps
module matrix_keypad_scanner_tb;
  import keypad_pkg::*;
  localparam int SC     = 4;
  localparam int PERIOD = 4 * (SC + 2);
  logic        clock, rstn, keypad_en, key_valid, key_event;
  logic [7:0]  gpio_out, gpio_oe, gpio_in, pin_in, pin_out, pin_oe;
  logic [7:0]  pin_pullup, ext_oe, ext_val;
  logic [3:0]  key_code;
  logic [3:0]  last_drv = 4'h0;
  logic [15:0] key_down, m;
  logic [3:0]  exp_q[$];
  int          error_cnt = 0;
  int          checks_done = 0;

  matrix_keypad_scanner #(.SETTLE_CYC(SC)) matrix_keypad_scanner_i (
    .clock(clock), .rstn(rstn), .keypad_en(keypad_en),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .key_code(key_code),
    .key_valid(key_valid), .key_event(key_event));

  keypad_model keypad_model_i (
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .key_down(key_down), .ext_oe(ext_oe), .ext_val(ext_val),
    .pin_in(pin_in));

  // ----------------------------------------------------------------
  // compare and helper tasks
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t port got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check_key(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t key got %0d exp %0d", $time, got, exp);
    end
  endtask : check_key

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask : cycles

  // release all keys, then hold the set and await its one report
  task automatic press(input logic [15:0] mask);
    int top;
    key_down = 16'h0000;
    cycles(3 * PERIOD);
    check_bit(key_valid, 1'b0);
    top = 0;
    for (int k = 0; k < 16; k++) if (mask[k]) top = k;
    // press as phase 0 starts, so one whole scan sees the full set and
    // a half-seen set cannot report a lower key first
    while (pin_out[3:0] !== 4'he) cycles(1);
    while (pin_out[3:0] !== 4'h7) cycles(1);
    exp_q.push_back(4'(top));
    key_down = mask;
    for (int i = 0; i < 4 * PERIOD && exp_q.size() != 0; i++) cycles(1);
    check8(8'(exp_q.size()), 8'h00);
    check_bit(key_valid, 1'b1);
  endtask : press

  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    if (rstn === 1'b1 && key_event === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("ERROR %0t unexpected key report", $time);
      end
      else check_key(key_code, exp_q.pop_front());
    end
    if (rstn === 1'b1 && keypad_en === 1'b1 && pin_oe === 8'h0f) begin
      check8({pin_out[7:4], 4'h0}, 8'hf0);
      check_bit($onehot(~pin_out[3:0]), 1'b1);
      // drive order 3,2,1,0 then wrap
      if (last_drv !== 4'h0 && pin_out[3:0] !== last_drv)
        check8({4'h0, pin_out[3:0]},
               {4'h0, last_drv[0], last_drv[3:1]});
      last_drv = pin_out[3:0];
    end
    else last_drv = 4'h0;
  end

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    int seed;
    seed = $urandom(32'hde20c6c2);
    rstn = 1'b0;
    keypad_en = 1'b0;
    gpio_out = 8'h00;
    gpio_oe = 8'h00;
    key_down = 16'h0000;
    ext_oe = 8'h00;
    ext_val = 8'h00;
    cycles(20);
    check8(pin_oe, 8'h00);
    check8(pin_pullup, 8'hff);
    rstn = 1'b1;
    keypad_en = 1'b1;
    for (int k = 0; k < 16; k++)
      press(16'h0001 << k);
    repeat (8) begin
      m = 16'($urandom);
      if (m == 16'h0000) m = 16'h8001;
      press(m);
    end
    // leaving keypad mode with a key still held drops the report
    keypad_en = 1'b0;
    cycles(1);
    check_bit(key_valid, 1'b0);
    key_down = 16'h0000;
    repeat (8) begin
      gpio_out = 8'($urandom);
      gpio_oe = 8'($urandom);
      ext_oe = ~gpio_oe & 8'($urandom);
      ext_val = 8'($urandom);
      cycles(1);
      check8(pin_oe, gpio_oe);
      check8(pin_out, gpio_out);
      cycles(2);
      check8(gpio_in, (gpio_oe & gpio_out) | (ext_oe & ext_val) |
             ~(gpio_oe | ext_oe));
    end
    check8(pin_pullup, 8'hff);
    // back to scanning after general-purpose use; quiet the port first
    gpio_oe = 8'h00;
    ext_oe = 8'h00;
    cycles(2);
    keypad_en = 1'b1;
    press(16'h0001 << $urandom_range(15, 0));
    conclude();
  end
endmodule : matrix_keypad_scanner_tb
